//--- verilog/pxc_cfg.svh
// Constants for the extended control register block.
`ifndef PXC_CFG_SVH
`define PXC_CFG_SVH
`define PXC_REG_ADDR 5'h10
`define PXC_BIT_OVR 15
`define PXC_ADDR_HI 10
`define PXC_ADDR_LO 6
`define PXC_BIT_SCR_TEST 5
`define PXC_BIT_NRZI 3
`define PXC_BIT_INV 2
`define PXC_BIT_SCR_DIS 0
`define PXC_RST_NRZI 1'b1
`define PXC_RST_ZERO 1'b0
`define PXC_LFSR_SEED 11'h7_FF
`define PXC_OVR_SET 1'b1
`define PXC_STRAP_WAIT 2'h3
`define PXC_STRAP_LAST 2'h1
`define PXC_STRAP_STEP 2'h1
`define PXC_STRAP_DONE 2'h0
`endif

//--- verilog/pxc_pkg.sv
// Types for the extended control register block.
package pxc_pkg;
  typedef struct packed {
    logic ovr_en;
    logic [4:0] port_addr;
    logic [1:0] strap_pend;
    logic scr_test;
    logic nrzi_sel;
    logic inv_code;
    logic scr_dis;
    logic [15:0] rd_data;
    logic [10:0] lfsr;
    logic nrzi_lvl;
    logic tx_bit;
    logic [4:0] tx_sym;
    logic scr_test_out;
    logic [4:0] sync_s1;
    logic [4:0] sync_s2;
  } pxc_state_s;
endpackage

//--- verilog/pxc_ext_ctrl.sv
// Extended control register of the PHY with its transmit-path controls.
// Operation
// - Protected bits change only when override armed.
// - Override enable self-clears after next write.
// - Reserved bits 14:11, 4, 1 read zero.
// - Hardware reset latches strapped port address.
// - Software reset keeps latched port address.
// - Scrambler test mode forces descrambler unlock at 100 Mb/s.
// - Encoding bit selects NRZ or NRZI.
// - Invalid-code bit clear gives standard 4B/5B.
// - Test nibbles 0-7 map to zero-prefixed code.
// - Test nibbles 8-F map to listed codes.
// - Scrambler disable bypasses scrambler and descrambler.
// - Scrambling applies only at 100 Mb/s.
`timescale 1ns/1ps
`include "pxc_cfg.svh"
module pxc_ext_ctrl (
  // Clock and resets.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sw_reset,
  // Management register access.
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_reg,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic override_protected_bit,
  // Strap pins, sampled after hardware reset.
  input wire logic addr_bit4_strap,
  input wire logic addr_bit3_strap,
  input wire logic addr_bit2_strap,
  input wire logic addr_bit1_strap,
  input wire logic addr_bit0_strap,
  output logic [4:0] port_addr,
  // Transmit data path.
  input wire logic speed_100,
  input wire logic tx_nib_valid,
  input wire logic [3:0] tx_nib,
  input wire logic tx_er,
  input wire logic [4:0] std_code,
  output logic [4:0] tx_sym,
  input wire logic tx_bit_valid,
  input wire logic tx_bit_in,
  output logic tx_serial,
  output logic scr_bypass,
  output logic descr_force_unlock
);
  // All state of the block lives in one registered struct.
  // The next value is built by one combinational process and
  // registered by one clocked process with a synchronous reset.
  pxc_pkg::pxc_state_s s_r;
  pxc_pkg::pxc_state_s s_nxt;

  // Register decode.
  logic hit_wr;
  logic hit_rd;
  logic arm_wr;

  // Strap pins gathered as one address word.
  logic [4:0] strap;

  // Transmit path helpers.
  logic [4:0] test_code;
  logic scr_bit;
  logic mixed;
  logic enc_bit;

  // The straps come from pins and are read only through the synchroniser.
  assign strap = {addr_bit4_strap, addr_bit3_strap, addr_bit2_strap,
                  addr_bit1_strap, addr_bit0_strap};

  // Writes to other registers still matter, since they use up the override.
  assign hit_wr = mgmt_wr && (mgmt_reg == `PXC_REG_ADDR);
  assign hit_rd = mgmt_rd && (mgmt_reg == `PXC_REG_ADDR);
  // A write to this register with the enable bit set arms the override.
  assign arm_wr = hit_wr && mgmt_wdata[`PXC_BIT_OVR];

  // Test translation used when invalid codes are asked for with TXER.
  // Nibbles below eight take a leading zero; the upper half uses a table.
  always_comb begin
    unique case (tx_nib)
      4'h8: test_code = 5'h00;
      4'h9: test_code = 5'h0D;
      4'hA: test_code = 5'h0C;
      4'hB: test_code = 5'h11;
      4'hC: test_code = 5'h10;
      4'hD: test_code = 5'h19;
      4'hE: test_code = 5'h18;
      4'hF: test_code = 5'h1F;
      default: test_code = {1'b0, tx_nib};
    endcase
  end

  // Scrambling only at 100 Mb/s and only when not disabled.
  // At 10 Mb/s the bit stream passes untouched whatever the disable bit holds.
  assign scr_bit = speed_100 && !s_r.scr_dis;
  assign mixed = scr_bit ? (tx_bit_in ^ s_r.lfsr[10]) : tx_bit_in;

  // In NRZI a one flips the line level; NRZ passes the bit as it is.
  assign enc_bit = s_r.nrzi_sel ? (s_r.nrzi_lvl ^ mixed) : mixed;

  always_comb begin
    s_nxt = s_r;

    // Straps pass two flops before anything reads them.
    s_nxt.sync_s1 = strap;
    s_nxt.sync_s2 = s_r.sync_s1;

    // The address is taken once after a hardware reset, when the
    // synchroniser has filled with the pin levels.
    // Straps are expected to stay put for a few cycles after reset.
    if (s_r.strap_pend != `PXC_STRAP_DONE) begin
      s_nxt.strap_pend = s_r.strap_pend - `PXC_STRAP_STEP;
      if (s_r.strap_pend == `PXC_STRAP_LAST) begin
        s_nxt.port_addr = s_r.sync_s2;
      end
    end

    // Override enable: an arming write sets it, any other write clears it.
    // The arming write itself never counts as the write that uses it up,
    // and a second arming write simply keeps it set.
    if (arm_wr) begin
      s_nxt.ovr_en = `PXC_OVR_SET;
    end else if (mgmt_wr) begin
      s_nxt.ovr_en = `PXC_RST_ZERO;
    end

    // Control bits of this register; reserved and address bits ignore writes.
    if (hit_wr) begin
      s_nxt.scr_test = mgmt_wdata[`PXC_BIT_SCR_TEST];
      s_nxt.nrzi_sel = mgmt_wdata[`PXC_BIT_NRZI];
      s_nxt.inv_code = mgmt_wdata[`PXC_BIT_INV];
      s_nxt.scr_dis = mgmt_wdata[`PXC_BIT_SCR_DIS];
    end

    // A software reset wins over a write in the same cycle.
    if (sw_reset) begin
      // Port address is left alone by a software reset.
      s_nxt.ovr_en = `PXC_RST_ZERO;
      s_nxt.scr_test = `PXC_RST_ZERO;
      s_nxt.nrzi_sel = `PXC_RST_NRZI;
      s_nxt.inv_code = `PXC_RST_ZERO;
      s_nxt.scr_dis = `PXC_RST_ZERO;
    end

    // Read data is captured on the strobe and held until the next read.
    // Reserved positions are forced to zero whatever was written there.
    if (hit_rd) begin
      s_nxt.rd_data = '0;
      s_nxt.rd_data[`PXC_BIT_OVR] = s_r.ovr_en;
      s_nxt.rd_data[`PXC_ADDR_HI:`PXC_ADDR_LO] = s_r.port_addr;
      s_nxt.rd_data[`PXC_BIT_SCR_TEST] = s_r.scr_test;
      s_nxt.rd_data[`PXC_BIT_NRZI] = s_r.nrzi_sel;
      s_nxt.rd_data[`PXC_BIT_INV] = s_r.inv_code;
      s_nxt.rd_data[`PXC_BIT_SCR_DIS] = s_r.scr_dis;
    end

    // Symbol path: the test table replaces the standard code only while
    // the invalid-code bit is set and the MAC raises TXER.
    if (tx_nib_valid) begin
      if (s_r.inv_code && tx_er) begin
        s_nxt.tx_sym = test_code;
      end else begin
        s_nxt.tx_sym = std_code;
      end
    end

    // The descrambler is held out of lock while test mode is on.
    // It only has a lock to lose on the 100 Mb/s path.
    s_nxt.scr_test_out = s_r.scr_test && speed_100;

    // Serial bit path: the scrambler steps once per bit.
    // The line level only tracks the stream while NRZI is selected.
    if (tx_bit_valid) begin
      s_nxt.lfsr = {s_r.lfsr[9:0], s_r.lfsr[10] ^ s_r.lfsr[8]};
      s_nxt.tx_bit = enc_bit;
      if (s_r.nrzi_sel) begin
        s_nxt.nrzi_lvl = enc_bit;
      end
    end
  end

  // Hardware reset restores every field and restarts the strap capture.
  // The synchroniser is cleared too, hence the wait before capture.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.strap_pend <= `PXC_STRAP_WAIT;
      s_r.nrzi_sel <= `PXC_RST_NRZI;
      s_r.lfsr <= `PXC_LFSR_SEED;
    end else begin
      s_r <= s_nxt;
    end
  end


  // Outputs; all but the bypass flag come straight from flops.
  assign mgmt_rdata = s_r.rd_data;
  // Protected bits elsewhere may be written only while this is high.
  assign override_protected_bit = s_r.ovr_en;
  assign port_addr = s_r.port_addr;
  assign tx_sym = s_r.tx_sym;
  assign tx_serial = s_r.tx_bit;
  assign scr_bypass = !scr_bit;
  assign descr_force_unlock = s_r.scr_test_out;
endmodule

//--- verification/pxc_properties.sv
// Checker for the extended control register block.
`timescale 1ns/1ps
module pxc_prop (
  // Watched ports.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sw_reset,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic override_protected_bit,
  input wire logic tx_nib_valid,
  input wire logic tx_er,
  input wire logic speed_100,
  input wire logic scr_bypass,
  input wire logic descr_force_unlock,
  input wire logic [3:0] tx_nib,
  input wire logic [4:0] mgmt_reg,
  input wire logic [4:0] port_addr,
  input wire logic [4:0] std_code,
  input wire logic [4:0] tx_sym,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata
);
  logic [5:0] c_r;
  wire ov = override_protected_bit;
  wire w10 = mgmt_wr && mgmt_reg == 5'h10;
  wire wa = w10 && mgmt_wdata[15];
  always_ff @(posedge clk) c_r <= !rst_n || sw_reset ? 6'h08 : w10 ? mgmt_wdata[5:0] : c_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  arm_set_a: assert property (wa && !sw_reset |=> ov) else $error("not armed");
  self_clear_a: assert property (ov && mgmt_wr && !wa |=> !ov) else $error("kept");
  rsvd_zero_a: assert property (mgmt_rd && mgmt_reg == 5'h10 |=>
    !(mgmt_rdata & 16'h7812)) else $error("reserved set");
  std_code_a: assert property (tx_nib_valid && !c_r[2] |=>
    tx_sym == $past(std_code)) else $error("bad code");
  inv_code_a: assert property (tx_nib_valid && tx_er && c_r[2] && !tx_nib[3] |=>
    tx_sym == {1'b0, $past(tx_nib)}) else $error("bad test code");
  bypass_on_a: assert property (!speed_100 || c_r[0] |-> scr_bypass)
    else $error("scrambling");
  unlock_a: assert property (speed_100 && c_r[5] && !sw_reset |=> descr_force_unlock)
    else $error("locked");
  addr_hold_a: assert property (sw_reset && $past(rst_n, 3) |=> $stable(port_addr))
    else $error("address moved");
  cover property (wa ##1 mgmt_wr);
  cover property (tx_nib_valid && tx_er && c_r[2] && tx_nib[3]);
  cover property (sw_reset);
endmodule
bind pxc_ext_ctrl pxc_prop u_prop (.*);

//--- verification/pxc_sta_model.sv
// Management controller model for the register port.
`timescale 1ns/1ps
module pxc_sta_model (
  // Management port.
  input wire logic clk,
  output logic mgmt_wr = '0, mgmt_rd = '0,
  output logic [4:0] mgmt_reg = '0,
  output logic [15:0] mgmt_wdata = '0
);
  task automatic op(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) {mgmt_wr, mgmt_rd} <= {w, !w};
    mgmt_reg <= a;
    mgmt_wdata <= d & 16'h87ED;
    @(posedge clk) {mgmt_wr, mgmt_rd} <= 2'h0;
  endtask
endmodule

//--- verification/tb.sv
// Bench for the extended control register block.
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst_n = 0, sw_reset = 0, speed_100 = 1, tx_nib_valid = 0, tx_er = 1;
  logic addr_bit4_strap = 1, addr_bit3_strap = 0, addr_bit2_strap = 1, addr_bit1_strap = 0;
  logic addr_bit0_strap = 1, tx_bit_valid = 0, tx_bit_in = 0, mgmt_wr, mgmt_rd;
  logic override_protected_bit, tx_serial, scr_bypass, descr_force_unlock;
  logic [3:0] tx_nib = 0;
  logic [4:0] mgmt_reg, std_code = 0, tx_sym, port_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [4:0] tbl [8] = '{5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
  int err_total = 0, num_checks = 0, cyc = 0;
  pxc_ext_ctrl u_dut (.*);
  pxc_sta_model u_sta (.*);
  always #2.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 3000) begin
    err_total++;
    tally_and_finish();
  end
  task automatic t_sw();
    u_sta.op(0, 5'h10, 16'h0000);
    @(negedge clk) chk(mgmt_rdata, 16'h0548);
    u_sta.op(1, 5'h10, 16'h8025);
    @(posedge clk) {sw_reset, addr_bit4_strap, addr_bit0_strap} <= 3'h4;
    @(posedge clk) sw_reset <= 1'b0;
    u_sta.op(0, 5'h10, 16'h0000);
    @(negedge clk) chk(mgmt_rdata, 16'h0548);
  endtask
  task automatic t_ovr();
    u_sta.op(1, 5'h10, 16'h8008);
    u_sta.op(1, 5'h10, 16'h8008);
    @(negedge clk) chk(override_protected_bit, 1'b1);
    u_sta.op(1, 5'h00, 16'h0000);
    @(negedge clk) chk(override_protected_bit, 1'b0);
  endtask
  task automatic t_code();
    u_sta.op(1, 5'h10, 16'h000C);
    for (int n = 0; n < 32; n++) begin
      if (n == 16) u_sta.op(1, 5'h10, 16'h0008);
      @(posedge clk) {tx_nib_valid, tx_nib, std_code} <= {1'b1, n[3:0], 5'(~n)};
      @(posedge clk) tx_nib_valid <= 1'b0;
      @(negedge clk) chk(tx_sym, n > 15 ? 5'(~n) : n < 8 ? n[4:0] : tbl[n - 8]);
    end
  endtask
  task automatic t_scr();
    u_sta.op(1, 5'h10, 16'h0021);
    @(negedge clk) chk(scr_bypass, 1'b1);
    @(negedge clk) chk(descr_force_unlock, 1'b1);
    u_sta.op(1, 5'h10, 16'h0008);
    @(negedge clk) chk(scr_bypass, 1'b0);
    @(posedge clk) speed_100 <= 1'b0;
    @(negedge clk) chk(scr_bypass, 1'b1);
  endtask
  task automatic t_ser();
    logic lvl;
    u_sta.op(1, 5'h10, 16'h0009);
    @(negedge clk) lvl = tx_serial;
    for (int n = 0; n < 16; n++) begin
      if (n == 8) u_sta.op(1, 5'h10, 16'h0001);
      @(posedge clk) {tx_bit_valid, tx_bit_in} <= {1'b1, n[0] ^ n[1]};
      @(posedge clk) tx_bit_valid <= 1'b0;
      lvl = (n < 8) ? (lvl ^ n[0] ^ n[1]) : (n[0] ^ n[1]);
      @(negedge clk) chk(tx_serial, lvl);
    end
  endtask
  task automatic t_hw();
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk) chk(port_addr, 5'h04);
    u_sta.op(0, 5'h10, 16'h0000);
    @(negedge clk) chk(mgmt_rdata, 16'h0108);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_sw();
    t_ovr();
    t_code();
    t_scr();
    t_ser();
    t_hw();
    tally_and_finish();
  end
endmodule
